// ===== hw/src_pkg.sv
package src_pkg;
  // ==================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int STATE_TIME_NS = 50;
  localparam int SEQ_STATES = 1040;
  localparam int SEQ_CYCLES = (SEQ_STATES * STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HW_MIN_LOW_STATES = 2;
  localparam int HW_MIN_LOW_CYCLES = (HW_MIN_LOW_STATES * STATE_TIME_NS) / CLK_PERIOD_NS;
  localparam int WDOG_OVF_STATES = 131072;
  localparam int WDOG_STATE_NS = 50;
  localparam int WDOG_OVF_CYCLES = (WDOG_OVF_STATES * WDOG_STATE_NS) / CLK_PERIOD_NS;
  localparam logic [7:0] WDOG_RELOAD = 8'h00;

  // ==================================================
  // reset values
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [7:0] RESET_CODE_SEG = 8'h00;
  localparam logic [9:0] DATA_PAGE_PTR_0_RESET = 10'h000;
  localparam logic [9:0] DPP1_RESET = 10'h001;
  localparam logic [9:0] DPP2_RESET = 10'h002;
  localparam logic [9:0] DPP3_RESET = 10'h003;

  // ==================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_WDOG_COUNT = 8'h10;

  // ==================================================
  // field positions
  localparam int ST_IN_RESET = 0;
  localparam int ST_RESET_OUT = 1;
  localparam int ST_WDOG_CAUSE = 2;
  localparam int ST_WDOG_EN = 3;
  localparam int ST_DIS_WINDOW = 4;
  localparam int ST_HW_LOW = 5;
  localparam int CTL_SOFT_RESET = 0;
  localparam int CTL_WDOG_SERVICE = 1;
  localparam int IRQ_HW = 0;
  localparam int IRQ_SW = 1;
  localparam int IRQ_WDOG = 2;
  localparam int IRQ_INIT_END = 3;
  localparam int IRQ_BITS = 4;
  localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 4'h0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SRC_RUN = 2'b00,
    SRC_WAIT_RAM = 2'b01,
    SRC_SEQ = 2'b10
  } src_state_t;

  typedef struct packed {
    logic [9:0] dpp3;
    logic [9:0] dpp2;
    logic [9:0] dpp1;
    logic [9:0] data_page_ptr_0;
  } src_dpp_t;

  typedef struct packed {
    logic [7:0] code_seg;
    logic [15:0] addr;
  } src_fetch_t;
endpackage

// ===== hw/src_top.sv
`timescale 1ns/1ps
// What this block does
// - reset starts on hardware pin low, software reset instruction, or watchdog overflow.
// - on reset start, cancel hold states and abort external bus cycles at once.
// - a running internal RAM write finishes before the reset sequence starts.
// - after the sequence or pin release, fetching starts at 0000h, segment zero.
// - a full internal reset sequence lasts 1040 state times.
// - a pin low pulse longer than 2 state times always causes a full reset.
// - pin still low at sequence end restarts the sequence until it is high.
// - reset output goes low on every reset source.
// - reset output stays low until end-of-init executes, then goes high.
// - at reset most special registers clear, disabling peripherals and interrupts; here irq_mask and irq_status keep their values through a triggered reset.
// - internal RAM, register banks and transfer pointers survive any reset.
// - data page pointer n is loaded with page n for n 0 to 3.
// - watchdog starts at reset end, reload 00h, overflows after 131072 states.
// - a watchdog overflow reset sets the watchdog reset cause flag.
// - the cause flag clears on hardware reset or watchdog service.
// - watchdog disable works only before first service or end-of-init.
// - during internal reset all port pins are inputs in high impedance.
module src_top #(
  parameter int WDOG_CYCLES = src_pkg::WDOG_OVF_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hw_reset_in_n,
  input wire logic software_reset_instr,
  input wire logic end_of_init_instr,
  input wire logic wdog_disable_instr,
  input wire logic wdog_service_instr,
  input wire logic ram_write_busy,
  output logic reset_out_n,
  output logic core_reset,
  output logic bus_abort,
  output logic port_hiz,
  output logic fetch_start,
  output src_pkg::src_fetch_t fetch_target,
  output src_pkg::src_dpp_t data_page_ptr,
  output logic wdog_reset_cause_flag,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import src_pkg::*;
  localparam int WDOG_W = $clog2(WDOG_CYCLES + 1);
  localparam logic [WDOG_W-1:0] WDOG_LAST = WDOG_W'(WDOG_CYCLES - 1);
  localparam logic [10:0] SEQ_LAST = 11'(SEQ_CYCLES - 1);
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == REG_STATUS) || (a == REG_CONTROL) || (a == REG_IRQ_STATUS) ||
              (a == REG_IRQ_MASK) || (a == REG_WDOG_COUNT);
  endfunction
  src_state_t state;
  logic [10:0] seq_cnt;
  logic pin_ff1, pin_ff2, pin_ff3, hw_low, wdog_en, dis_window, init_done;
  logic [WDOG_W-1:0] wdog_cnt;
  logic ctl_soft_reset, ctl_service, have_aw, have_w;
  logic [IRQ_BITS-1:0] irq_status, irq_mask, irq_ev;
  logic [7:0] aw_addr;
  logic [31:0] w_data, status_word;
  logic [3:0] w_strb;
  logic sw_req, service, wdog_ovf, trig, seq_end, seq_done, wr_fire;
  // ==================================================
  // reset pin synchroniser and low-time filter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_ff1 <= 1'b1;
      pin_ff2 <= 1'b1;
      pin_ff3 <= 1'b1;
    end else begin
      pin_ff1 <= hw_reset_in_n;
      pin_ff2 <= pin_ff1;
      pin_ff3 <= pin_ff2;
    end
  end
  // a level counts only once two stages agree, i.e. it stood two state times
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hw_low <= 1'b0;
    end else if (pin_ff2 == pin_ff3) begin
      hw_low <= ~pin_ff3;
    end
  end
  // ==================================================
  // reset sources
  assign sw_req = software_reset_instr | ctl_soft_reset;
  assign service = wdog_service_instr | ctl_service;
  assign wdog_ovf = wdog_en && (state == SRC_RUN) && (wdog_cnt == WDOG_LAST);
  assign trig = (state == SRC_RUN) && (hw_low || sw_req || wdog_ovf);
  assign seq_end = (state == SRC_SEQ) && (seq_cnt == SEQ_LAST);
  assign seq_done = seq_end && !hw_low;
  // ==================================================
  // sequence state machine
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= SRC_SEQ;
      seq_cnt <= 11'h000;
    end else begin
      case (state)
        SRC_RUN: begin
          seq_cnt <= 11'h000;
          if (trig) begin
            state <= ram_write_busy ? SRC_WAIT_RAM : SRC_SEQ;
          end
        end
        SRC_WAIT_RAM: begin
          seq_cnt <= 11'h000;
          if (!ram_write_busy) begin
            state <= SRC_SEQ;
          end
        end
        SRC_SEQ: begin
          if (seq_end) begin
            seq_cnt <= 11'h000;
            if (!hw_low) begin
              state <= SRC_RUN;
            end
          end else begin
            seq_cnt <= seq_cnt + 11'h001;
          end
        end
        default: begin
          state <= SRC_SEQ;
          seq_cnt <= 11'h000;
        end
      endcase
    end
  end
  // held in reset from the trigger edge on, so bus abort needs no ready
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_abort <= 1'b1;
      core_reset <= 1'b1;
      port_hiz <= 1'b1;
    end else begin
      bus_abort <= trig || ((state != SRC_RUN) && !seq_done);
      core_reset <= trig || ((state != SRC_RUN) && !seq_done);
      port_hiz <= trig || ((state != SRC_RUN) && !seq_done);
    end
  end
  // only registers are defaulted; no path reaches the internal RAM
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fetch_start <= 1'b0;
      fetch_target <= '0;
      data_page_ptr <= '0;
    end else begin
      fetch_start <= seq_done;
      if (seq_done) begin
        fetch_target <= '{code_seg: RESET_CODE_SEG, addr: RESET_VECTOR};
        data_page_ptr <= '{dpp3: DPP3_RESET, dpp2: DPP2_RESET,
                           dpp1: DPP1_RESET, data_page_ptr_0: DATA_PAGE_PTR_0_RESET};
      end
    end
  end
  // ==================================================
  // reset output
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reset_out_n <= 1'b0;
      init_done <= 1'b0;
    end else if (trig || state != SRC_RUN) begin
      reset_out_n <= 1'b0;
      init_done <= 1'b0;
    end else if (end_of_init_instr) begin
      reset_out_n <= 1'b1;
      init_done <= 1'b1;
    end
  end
  // ==================================================
  // watchdog
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wdog_cnt <= '0;
    end else if (state != SRC_RUN || service || wdog_ovf) begin
      wdog_cnt <= WDOG_W'(WDOG_RELOAD);
    end else if (wdog_en) begin
      wdog_cnt <= wdog_cnt + WDOG_W'(1);
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wdog_en <= 1'b0;
      dis_window <= 1'b0;
    end else if (seq_done) begin
      wdog_en <= 1'b1;
      dis_window <= 1'b1;
    end else if (state == SRC_RUN) begin
      if (dis_window && wdog_disable_instr) begin
        wdog_en <= 1'b0;
      end
      if (service || end_of_init_instr) begin
        dis_window <= 1'b0;
      end
    end
  end
  // set wins over clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wdog_reset_cause_flag <= 1'b0;
    end else if (wdog_ovf) begin
      wdog_reset_cause_flag <= 1'b1;
    end else if (hw_low || service) begin
      wdog_reset_cause_flag <= 1'b0;
    end
  end
  // ==================================================
  // interrupts
  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_HW] = trig && hw_low;
    irq_ev[IRQ_SW] = trig && sw_req;
    irq_ev[IRQ_WDOG] = wdog_ovf;
    irq_ev[IRQ_INIT_END] = (state == SRC_RUN) && !init_done && end_of_init_instr;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_status <= '0;
      irq_mask <= IRQ_MASK_RESET;
      irq <= 1'b0;
    end else begin
      for (int i = 0; i < IRQ_BITS; i++) begin
        if (irq_ev[i]) begin
          irq_status[i] <= 1'b1;
        end else if (wr_fire && aw_addr == REG_IRQ_STATUS && w_strb[0] && w_data[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
      if (wr_fire && aw_addr == REG_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[IRQ_BITS-1:0];
      end
      irq <= |(irq_status & irq_mask);
    end
  end
  // ==================================================
  // axi4-lite write channel
  assign wr_fire = have_aw && have_w && !s_axi_bvalid;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w <= 1'b1;
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // control bits are one-cycle command pulses
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl_soft_reset <= 1'b0;
      ctl_service <= 1'b0;
    end else begin
      ctl_soft_reset <= wr_fire && aw_addr == REG_CONTROL && w_strb[0] &&
                        w_data[CTL_SOFT_RESET];
      ctl_service <= wr_fire && aw_addr == REG_CONTROL && w_strb[0] &&
                     w_data[CTL_WDOG_SERVICE];
    end
  end
  // ==================================================
  // axi4-lite read channel
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_IN_RESET] = state != SRC_RUN;
    status_word[ST_RESET_OUT] = reset_out_n;
    status_word[ST_WDOG_CAUSE] = wdog_reset_cause_flag;
    status_word[ST_WDOG_EN] = wdog_en;
    status_word[ST_DIS_WINDOW] = dis_window;
    status_word[ST_HW_LOW] = hw_low;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        REG_STATUS: s_axi_rdata <= status_word;
        REG_IRQ_STATUS: s_axi_rdata <= 32'(irq_status);
        REG_IRQ_MASK: s_axi_rdata <= 32'(irq_mask);
        REG_WDOG_COUNT: s_axi_rdata <= 32'(wdog_cnt);
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // ==================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_trigger;
    (state == SRC_RUN) && hw_low |=> (state != SRC_RUN);
  endproperty
  a_trigger: assert property (p_trigger) else $error("pin low did not start reset");
  property p_abort;
    (state == SRC_WAIT_RAM) |-> bus_abort && core_reset && port_hiz;
  endproperty
  a_abort: assert property (p_abort) else $error("bus not aborted in reset");
  property p_ram_wait;
    (state == SRC_WAIT_RAM) && ram_write_busy |=> (state == SRC_WAIT_RAM) && (seq_cnt == 11'h000);
  endproperty
  a_ram_wait: assert property (p_ram_wait) else $error("sequence began during ram write");
  property p_seq_end;
    seq_end && !hw_low |=> (state == SRC_RUN) && fetch_start &&
      (fetch_target.addr == RESET_VECTOR) && !core_reset;
  endproperty
  a_seq_end: assert property (p_seq_end) else $error("sequence end did not start fetch");
  property p_seq_len;
    $rose(state == SRC_SEQ) |-> (seq_cnt == 11'h000);
  endproperty
  a_seq_len: assert property (p_seq_len) else $error("sequence not started from zero");
  property p_restart;
    seq_end && hw_low |=> (state == SRC_SEQ) && (seq_cnt == 11'h000) ##1 seq_cnt == 11'h001;
  endproperty
  a_restart: assert property (p_restart) else $error("sequence not restarted");
  property p_reset_out_n_low;
    trig |=> !reset_out_n [*2];
  endproperty
  a_reset_out_n_low: assert property (p_reset_out_n_low) else $error("reset output not low");
  property p_reset_out_n_high;
    (state == SRC_RUN) && end_of_init_instr && !trig |=> reset_out_n;
  endproperty
  a_reset_out_n_high: assert property (p_reset_out_n_high) else $error("reset output stuck low");
  property p_dpp;
    fetch_start |-> (data_page_ptr.dpp2 == DPP2_RESET) && (data_page_ptr.dpp3 == DPP3_RESET);
  endproperty
  a_dpp: assert property (p_dpp) else $error("page pointers wrong after reset");
  property p_wdog_run;
    seq_done |=> wdog_en && (wdog_cnt == '0) ##1 (wdog_cnt == WDOG_W'(1)) || !wdog_en;
  endproperty
  a_wdog_run: assert property (p_wdog_run) else $error("watchdog not running");
  property p_cause_set;
    wdog_ovf |=> wdog_reset_cause_flag && (state != SRC_RUN);
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("cause flag not set");
  property p_cause_clr;
    hw_low && !wdog_ovf |=> !wdog_reset_cause_flag;
  endproperty
  a_cause_clr: assert property (p_cause_clr) else $error("cause flag not cleared");
  property p_disable_late;
    (state == SRC_RUN) && !dis_window && !seq_done |=> wdog_en == $past(wdog_en);
  endproperty
  a_disable_late: assert property (p_disable_late) else $error("late disable took effect");
  property p_sync;
    (pin_ff2 != pin_ff3) |=> $stable(hw_low);
  endproperty
  a_sync: assert property (p_sync) else $error("unfiltered pin change");
  c_hw_reset: cover property (irq_status[IRQ_HW] && fetch_start);
  c_wdog_reset: cover property (wdog_ovf ##1 wdog_reset_cause_flag);
  c_restart: cover property (seq_end && hw_low);
  c_init_end: cover property ($rose(reset_out_n));
endmodule

// ===== testbench/src_reset_ext.sv
`timescale 1ns/1ps
// ==================================================
// external reset circuit model
module src_reset_ext (
  input wire logic ref_clk,
  output logic hw_reset_in_n
);
  logic drive_low = 1'b0;
  // released pin is pulled up, so it reads high outside a pulse
  assign hw_reset_in_n = drive_low ? 1'b0 : 1'b1;
  task automatic hold_low(input int n);
    // never shorter than the minimum low time
    if (n < 3) n = 3;
    @(posedge ref_clk);
    drive_low <= 1'b1;
    repeat (n) @(posedge ref_clk);
    drive_low <= 1'b0;
  endtask
endmodule

// ===== testbench/test_system_reset_controller.sv
`timescale 1ns/1ps
// ==================================================
// bench
module test_system_reset_controller;
  import src_pkg::*;
  localparam int WD = 64;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  localparam logic [3:0] I_SW = 4'h1, I_EOI = 4'h2, I_DIS = 4'h4, I_SVC = 4'h8;
  logic [3:0] instr = 4'h0;
  logic busy = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic pin_n, rst_out_n, core_reset, bus_abort, port_hiz, fetch_start, flag, irq;
  src_fetch_t tgt;
  src_dpp_t dpp;
  int failures = 0;
  int total_checks = 0;
  logic [31:0] d;
  logic [1:0] r;
  int n;

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  src_reset_ext u_ext (.ref_clk(ref_clk), .hw_reset_in_n(pin_n));

  src_top #(.WDOG_CYCLES(WD)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .hw_reset_in_n(pin_n), .software_reset_instr(instr[0]),
    .end_of_init_instr(instr[1]), .wdog_disable_instr(instr[2]),
    .wdog_service_instr(instr[3]),
    .ram_write_busy(busy), .reset_out_n(rst_out_n), .core_reset(core_reset),
    .bus_abort(bus_abort), .port_hiz(port_hiz), .fetch_start(fetch_start),
    .fetch_target(tgt), .data_page_ptr(dpp), .wdog_reset_cause_flag(flag), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // ==================================================
  // shared tasks
  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic hang(input int i, input int lim);
    if (i >= lim) begin
      failures++;
      $display("mismatch wait expected done seen timeout");
      end_of_test();
    end
  endtask

  task automatic pulse(input logic [3:0] m);
    instr <= m;
    @(posedge ref_clk);
    instr <= 4'h0;
    @(posedge ref_clk);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    int i;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    hang(i, 50);
  endtask

  task automatic axr(input logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    hang(i, 50);
  endtask

  task automatic wait_fetch();
    for (n = 1; n < 2500; n++) begin
      @(posedge ref_clk);
      if (fetch_start === 1'b1) break;
    end
    hang(n, 2500);
  endtask

  // ==================================================
  // scenarios
  task automatic s_boot();
    repeat (10) @(posedge ref_clk);
    chk("held", 32'hb, {28'h0, port_hiz, rst_out_n, bus_abort, core_reset});
    wait_fetch();
    chk("seq_len", 32'h1, 32'(n + 10 >= SEQ_CYCLES && n + 10 <= SEQ_CYCLES + 4));
    chk("target", 32'h0, 32'(tgt));
    chk("dpp", {12'h000, DPP3_RESET, DPP2_RESET}, 32'(dpp >> 20));
    chk("dpp1", 32'(DPP1_RESET), 32'(dpp.dpp1));
    chk("data_page_ptr_0", 32'(DATA_PAGE_PTR_0_RESET), 32'(dpp.data_page_ptr_0));
    chk("out_low", 32'h0, 32'(rst_out_n));
    pulse(I_DIS);
    axr(REG_STATUS);
    chk("disabled", 32'h0, d & 32'h0f);
  endtask

  task automatic s_init_irq();
    pulse(I_EOI);
    @(posedge ref_clk);
    chk("out_high", 32'h1, 32'(rst_out_n));
    axr(REG_IRQ_STATUS);
    chk("irq_st", 32'h8, d);
    chk("irq_off", 32'h0, 32'(irq));
    axw(REG_IRQ_MASK, 32'h8);
    chk("bresp", 32'(RESP_OKAY), 32'(r));
    repeat (3) @(posedge ref_clk);
    chk("irq_on", 32'h1, 32'(irq));
    axw(REG_IRQ_STATUS, 32'h8);
    repeat (3) @(posedge ref_clk);
    chk("irq_clr", 32'h0, 32'(irq));
    axr(8'h40);
    chk("unmapped", {30'h0, RESP_SLVERR}, {d[29:0], r});
  endtask

  task automatic s_soft_wdog();
    busy <= 1'b1;
    pulse(I_SW);
    repeat (20) @(posedge ref_clk);
    chk("abort", 32'h2, {30'h0, bus_abort, rst_out_n});
    busy <= 1'b0;
    wait_fetch();
    chk("ram_wait", 32'h1, 32'(n >= SEQ_CYCLES && n <= SEQ_CYCLES + 4));
    for (n = 1; n < 200; n++) begin
      @(posedge ref_clk);
      if (core_reset === 1'b1) break;
    end
    hang(n, 200);
    chk("wdog_time", 32'h1, 32'(n >= WD && n <= WD + 4));
    chk("wdog_out", 32'h0, 32'(rst_out_n));
    wait_fetch();
    chk("cause", 32'h1, 32'(flag));
    pulse(I_SVC);
    @(posedge ref_clk);
    chk("cause_clr", 32'h0, 32'(flag));
    axw(REG_CONTROL, 32'h2);
    axr(REG_WDOG_COUNT);
    chk("wdog_svc", 32'h1, 32'(d < 4));
    pulse(I_DIS);
    axr(REG_STATUS);
    chk("late_dis", 32'h8, d & 32'h8);
  endtask

  task automatic s_pin();
    u_ext.hold_low(3);
    for (n = 1; n < 12; n++) begin
      @(posedge ref_clk);
      if (core_reset === 1'b1) break;
    end
    hang(n, 12);
    wait_fetch();
    fork
      u_ext.hold_low(SEQ_CYCLES + 200);
      begin
        repeat (SEQ_CYCLES + 100) @(posedge ref_clk);
        chk("repeat", 32'h1, 32'(core_reset));
      end
    join
    wait_fetch();
    n = n + SEQ_CYCLES + 201;
    chk("pin_len", 32'h1, 32'(n >= 2 * SEQ_CYCLES && n <= 2 * SEQ_CYCLES + 12));
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    s_boot();
    s_init_irq();
    s_soft_wdog();
    s_pin();
    end_of_test();
  end
endmodule
